// File: hw/bgd_defs.svh
`ifndef BGD_DEFS_SVH
`define BGD_DEFS_SVH

`define BGD_FLASH_BASE_NORM 32'h0000_0000
`define BGD_FLASH_LIM_NORM 32'h00ff_ffff
`define BGD_FLASH_BASE_BOOT 32'h0100_0000
`define BGD_FLASH_LIM_BOOT 32'h01ff_ffff
`define BGD_ROM_BASE 32'h0000_0000
`define BGD_ROM_LIM_4M 32'h003f_ffff
`define BGD_ROM_LIM_1M 32'h000f_ffff
`define BGD_ISA_MEM_LO 32'h0800_0000
`define BGD_ISA_MEM_HI 32'h0bff_ffff
`define BGD_ISA_IO_LO 32'h0c00_0000
`define BGD_ISA_IO_HI 32'h0dff_ffff
`define BGD_ISA_DACK_LO 32'h0e00_0000
`define BGD_ISA_DACK_HI 32'h0fff_ffff
`define BGD_ETH_FAST_LO 32'h0334_0c00
`define BGD_ETH_FAST_HI 32'h0334_8fff
`define BGD_ETH_MED_LO 32'h032c_0c00
`define BGD_ETH_MED_HI 32'h032c_0cff
`define BGD_ETH_SLOW_LO 32'h0324_0c00
`define BGD_ETH_SLOW_HI 32'h0324_0cff
`define BGD_LED_LO 32'h0302_ba00
`define BGD_LED_HI 32'h0302_baff
`define BGD_ISTAT_LO 32'h0302_b000
`define BGD_ISTAT_HI 32'h0302_b7ff
`define BGD_IRQ_W 9
`define BGD_IRQ_ISA_DMA 0
`define BGD_IRQ_LPT 1
`define BGD_IRQ_UNUSED 2
`define BGD_IRQ_ETH 3
`define BGD_IRQ_ETH_DMA 4
`define BGD_IRQ_COM1 5
`define BGD_IRQ_ISA 6
`define BGD_IRQ_GP 7
`define BGD_IRQ_COM2 8
`define BGD_SIMM_W 7
`define BGD_ISA_DRQ_W 8
`define BGD_ISA_IRQ_W 8

`endif

// File: hw/bgd_pkg.sv
package bgd_pkg;

    typedef struct packed {
        logic rom;
        logic flash;
        logic isa_mem;
        logic isa_io;
        logic isa_dack;
        logic eth_io;
        logic led_status;
        logic irq_status;
    } bgd_sel_t;

    typedef enum logic [2:0] {
        BGD_ST_RESET = 3'b001,
        BGD_ST_STRAP = 3'b010,
        BGD_ST_RUN = 3'b100
    } bgd_state_t;

endpackage : bgd_pkg

// File: hw/bgd_sync.sv
`timescale 1ns/10ps
`include "bgd_defs.svh"

// ----------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------
module bgd_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            meta <= '0;
            dout <= '0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : bgd_sync

// File: hw/bgd_glue.sv
`timescale 1ns/10ps
`include "bgd_defs.svh"

module bgd_glue (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [31:0] cpu_addr,
    input wire logic cpu_read,
    input wire logic expansion_chip_select_n,
    input wire logic simple_io_select_two_n,
    input wire logic peripheral_select_one_n,
    input wire logic peripheral_select_two_n,
    input wire logic rom_space_select_n,
    input wire logic boot_mode_strap,
    input wire logic rom_size_strap,
    input wire logic clock_relation_strap,
    input wire logic [6:0] simm_info,
    input wire logic [7:0] isa_drq,
    input wire logic [7:0] isa_irq,
    input wire logic eth_irq,
    input wire logic eth_drq,
    input wire logic lpt_irq,
    input wire logic com1_irq,
    input wire logic com2_irq,
    input wire logic gp_irq,
    output bgd_pkg::bgd_sel_t dev_sel,
    output logic [6:0] simm_status,
    output logic [8:0] cpu_irq,
    output logic clock_sync_strap,
    output logic boot_rom_enabled,
    output logic rom_is_4m
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] strap_sync;
    logic [6:0] simm_sync;
    logic [`BGD_ISA_DRQ_W-1:0] isa_drq_sync;
    logic [`BGD_ISA_IRQ_W-1:0] isa_irq_sync;
    logic eth_irq_sync;
    logic eth_drq_sync;
    logic lpt_irq_sync;
    logic com1_irq_sync;
    logic com2_irq_sync;
    logic gp_irq_sync;

    bgd_sync #(.W(3)) u_strap_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din({boot_mode_strap, rom_size_strap, clock_relation_strap}),
        .dout(strap_sync)
    );

    bgd_sync #(.W(`BGD_SIMM_W)) u_simm_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(simm_info),
        .dout(simm_sync)
    );

    bgd_sync #(.W(`BGD_ISA_DRQ_W)) u_isa_drq_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(isa_drq),
        .dout(isa_drq_sync)
    );

    bgd_sync #(.W(`BGD_ISA_IRQ_W)) u_isa_irq_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(isa_irq),
        .dout(isa_irq_sync)
    );

    bgd_sync u_eth_irq_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(eth_irq),
        .dout(eth_irq_sync)
    );

    bgd_sync u_eth_drq_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(eth_drq),
        .dout(eth_drq_sync)
    );

    bgd_sync u_lpt_irq_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(lpt_irq),
        .dout(lpt_irq_sync)
    );

    bgd_sync u_com1_irq_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(com1_irq),
        .dout(com1_irq_sync)
    );

    bgd_sync u_com2_irq_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(com2_irq),
        .dout(com2_irq_sync)
    );

    bgd_sync u_gp_irq_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(gp_irq),
        .dout(gp_irq_sync)
    );

    // ----------------------------------------
    // Strap capture
    // ----------------------------------------
    // Straps are latched once after reset; moving a shunt live would remap
    // code under the running processor.
    bgd_pkg::bgd_state_t state;
    logic boot_rom_on;
    logic rom_4m;
    logic sync_full;

    // Sync stages clear in reset, so the strap sample waits one more edge
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sync_full <= 1'b0;
        end
        else
        begin
            sync_full <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            state <= bgd_pkg::BGD_ST_RESET;
        end
        else
        begin
            case (state)
                bgd_pkg::BGD_ST_RESET: state <= sync_full ? bgd_pkg::BGD_ST_STRAP : state;
                bgd_pkg::BGD_ST_STRAP: state <= bgd_pkg::BGD_ST_RUN;
                bgd_pkg::BGD_ST_RUN: state <= bgd_pkg::BGD_ST_RUN;
                default: state <= bgd_pkg::BGD_ST_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            boot_rom_on <= 1'b0;
            rom_4m <= 1'b0;
            clock_sync_strap <= 1'b0;
        end
        else if (state == bgd_pkg::BGD_ST_STRAP)
        begin
            boot_rom_on <= strap_sync[2];
            rom_4m <= strap_sync[1];
            clock_sync_strap <= strap_sync[0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            boot_rom_enabled <= 1'b0;
            rom_is_4m <= 1'b0;
        end
        else
        begin
            boot_rom_enabled <= boot_rom_on;
            rom_is_4m <= rom_4m;
        end
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    bgd_pkg::bgd_sel_t next_sel;
    logic [31:0] rom_lim;
    logic running;

    assign running = (state == bgd_pkg::BGD_ST_RUN);
    assign rom_lim = rom_4m ? `BGD_ROM_LIM_4M : `BGD_ROM_LIM_1M;

    always_comb
    begin
        next_sel = '0;
        if (!running)
        begin
            next_sel = '0;
        end
        else if (!rom_space_select_n)
        begin
            if (boot_rom_on)
            begin
                next_sel.rom = in_range(cpu_addr, `BGD_ROM_BASE, rom_lim);
                next_sel.flash = in_range(cpu_addr, `BGD_FLASH_BASE_BOOT,
                                          `BGD_FLASH_LIM_BOOT);
            end
            else
            begin
                // ROM unreachable with strap off
                next_sel.flash = in_range(cpu_addr, `BGD_FLASH_BASE_NORM,
                                          `BGD_FLASH_LIM_NORM);
            end
        end
        else if (!expansion_chip_select_n)
        begin
            next_sel.isa_mem = in_range(cpu_addr, `BGD_ISA_MEM_LO, `BGD_ISA_MEM_HI);
            next_sel.isa_io = in_range(cpu_addr, `BGD_ISA_IO_LO, `BGD_ISA_IO_HI);
            next_sel.isa_dack = in_range(cpu_addr, `BGD_ISA_DACK_LO, `BGD_ISA_DACK_HI);
        end
        else if (!simple_io_select_two_n)
        begin
            next_sel.eth_io = in_range(cpu_addr, `BGD_ETH_FAST_LO, `BGD_ETH_FAST_HI)
                || in_range(cpu_addr, `BGD_ETH_MED_LO, `BGD_ETH_MED_HI)
                || in_range(cpu_addr, `BGD_ETH_SLOW_LO, `BGD_ETH_SLOW_HI);
        end
        else if (!peripheral_select_one_n)
        begin
            next_sel.led_status = in_range(cpu_addr, `BGD_LED_LO, `BGD_LED_HI);
        end
        else if (!peripheral_select_two_n)
        begin
            next_sel.irq_status = cpu_read
                && in_range(cpu_addr, `BGD_ISTAT_LO, `BGD_ISTAT_HI);
        end
    end

    // Priority chain above already yields one hot or none
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            dev_sel <= '0;
        end
        else
        begin
            dev_sel <= next_sel;
        end
    end

    // ----------------------------------------
    // Flash module status
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            simm_status <= '0;
        end
        else
        begin
            simm_status <= simm_sync;
        end
    end

    // ----------------------------------------
    // Interrupt routing
    // ----------------------------------------
    logic [8:0] next_irq;

    always_comb
    begin
        next_irq = '0;
        next_irq[`BGD_IRQ_ISA_DMA] = |isa_drq_sync;
        next_irq[`BGD_IRQ_ISA] = |isa_irq_sync;
        next_irq[`BGD_IRQ_ETH] = eth_irq_sync;
        next_irq[`BGD_IRQ_ETH_DMA] = eth_drq_sync;
        next_irq[`BGD_IRQ_LPT] = lpt_irq_sync;
        next_irq[`BGD_IRQ_COM1] = com1_irq_sync;
        next_irq[`BGD_IRQ_COM2] = com2_irq_sync;
        next_irq[`BGD_IRQ_GP] = gp_irq_sync;
        next_irq[`BGD_IRQ_UNUSED] = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            cpu_irq <= '0;
        end
        else
        begin
            cpu_irq <= next_irq;
        end
    end
endmodule : bgd_glue

// File: dv/bgd_glue_asserts.sv
`timescale 1ns/10ps
// --------
// Checker
// --------
module bgd_glue_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [31:0] cpu_addr,
    input wire logic rom_space_select_n,
    input wire logic expansion_chip_select_n,
    input wire logic [7:0] isa_irq,
    input wire logic eth_irq,
    input bgd_pkg::bgd_sel_t dev_sel,
    input wire logic [8:0] cpu_irq,
    input wire logic boot_rom_enabled
);
    logic [2:0] cnt;
    // Decode is valid only some edges after release
    wire logic run = (cnt == 3'h6);
    wire logic rn = rom_space_select_n;
    wire logic bt = boot_rom_enabled;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clk_sys)
        cnt <= !reset_n ? 3'h0 : cnt + 3'(cnt != 3'h6);
    property p_one;
        $onehot0(dev_sel);
    endproperty
    a_one: assert property (p_one) else $error("two selects");
    property p_off;
        !bt |-> !dev_sel.rom;
    endproperty
    a_off: assert property (p_off) else $error("rom while off");
    property p_fb;
        run && bt && !rn && cpu_addr[31:24] == 8'h01 |=> dev_sel.flash;
    endproperty
    a_fb: assert property (p_fb) else $error("flash moved");
    property p_fn;
        run && !bt && !rn && cpu_addr[31:24] == 8'h00 |=> dev_sel.flash;
    endproperty
    a_fn: assert property (p_fn) else $error("flash base");
    property p_rom;
        run && bt && !rn && cpu_addr < 32'h0010_0000 |=> dev_sel.rom;
    endproperty
    a_rom: assert property (p_rom) else $error("rom");
    property p_isa;
        run && rn && !expansion_chip_select_n && cpu_addr[31:26] == 6'h02 |=> dev_sel.isa_mem;
    endproperty
    a_isa: assert property (p_isa) else $error("isa mem");
    property p_iq;
        run |-> cpu_irq[6] == (|$past(isa_irq, 3));
    endproperty
    a_iq: assert property (p_iq) else $error("isa irq");
    property p_eq;
        run |-> cpu_irq[3] == $past(eth_irq, 3) && !cpu_irq[2];
    endproperty
    a_eq: assert property (p_eq) else $error("eth irq");
    c_rom: cover property (dev_sel.rom);
    c_isa: cover property (dev_sel.isa_mem);
    c_irq: cover property (cpu_irq[6]);
endmodule : bgd_glue_chk

bind bgd_glue bgd_glue_chk i_bgd_glue_chk (.clk_sys, .reset_n, .cpu_addr,
    .rom_space_select_n, .expansion_chip_select_n, .isa_irq, .eth_irq, .dev_sel,
    .cpu_irq, .boot_rom_enabled);

// File: dv/bgd_cpu_model.sv
`timescale 1ns/10ps
// --------
// Processor bus
// --------
module bgd_cpu_model (
    input wire logic clk_sys,
    output logic [31:0] cpu_addr = 32'h0,
    output logic cpu_read = 1'b0,
    output logic [4:0] cs_n = 5'h1f
);
    // s: 0 rom, 1 exp, 2 sio2, 3 p1, 4 p2, 5 none
    task acc(input int s, input logic [31:0] a, input logic r);
        @(posedge clk_sys);
        #1 cs_n = ~(5'h10 >> s);
        cpu_addr = a;
        cpu_read = r;
        @(posedge clk_sys);
        // Released bus shows junk, not the old address
        #1 cs_n = 5'h1f;
        cpu_addr = ~a;
        cpu_read = ~r;
    endtask : acc
endmodule : bgd_cpu_model

// File: dv/board_address_decode_irq_routing_bench.sv
`timescale 1ns/10ps
// --------
// Bench
// --------
module board_address_decode_irq_routing_bench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] st = 3'h0;
    logic [21:0] src = 22'h0;
    wire logic [31:0] cpu_addr;
    wire logic cpu_read;
    wire logic [4:0] cs_n;
    wire logic [2:0] lat;
    wire logic [6:0] simm_status;
    wire logic [8:0] cpu_irq;
    bgd_pkg::bgd_sel_t dev_sel;
    int errors = 0;
    int n_compared = 0;
    initial forever #25 clk_sys = ~clk_sys;
    bgd_cpu_model i_bgd_cpu_model (.clk_sys, .cpu_addr, .cpu_read, .cs_n);
    bgd_glue i_bgd_glue (.clk_sys, .reset_n, .cpu_addr, .cpu_read,
        .rom_space_select_n(cs_n[4]), .expansion_chip_select_n(cs_n[3]),
        .simple_io_select_two_n(cs_n[2]), .peripheral_select_one_n(cs_n[1]),
        .peripheral_select_two_n(cs_n[0]), .boot_mode_strap(st[2]),
        .rom_size_strap(st[1]), .clock_relation_strap(st[0]), .simm_info(src[6:0]),
        .isa_drq(src[21:14]), .isa_irq(src[13:6]), .eth_irq(src[5]),
        .eth_drq(src[4]), .lpt_irq(src[3]), .com1_irq(src[2]), .com2_irq(src[1]),
        .gp_irq(src[0]), .dev_sel, .simm_status, .cpu_irq,
        .clock_sync_strap(lat[0]), .boot_rom_enabled(lat[2]), .rom_is_4m(lat[1]));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        errors += int'(got !== exp);
        if (got !== exp)
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    endtask : chk
    task dec(input int s, input logic [31:0] a, input logic r, input logic [7:0] e);
        i_bgd_cpu_model.acc(s, a, r);
        chk({24'h0, dev_sel}, {24'h0, e});
    endtask : dec
    // Straps are latched once, so each set needs a fresh reset
    task rst(input logic [2:0] s);
        st = s;
        reset_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1 chk({29'h0, lat}, {29'h0, s});
    endtask : rst
    task t_norm;
        rst(3'h3);
        dec(0, 32'h00ff_ffff, 1'b1, 8'h40);
        dec(0, 32'h0100_0000, 1'b0, 8'h00);
        $display("t_norm done");
    endtask : t_norm
    task t_boot;
        rst(3'h6);
        dec(0, 32'h003f_ffff, 1'b1, 8'h80);
        dec(0, 32'h0100_0000, 1'b1, 8'h40);
        rst(3'h4);
        dec(0, 32'h000f_ffff, 1'b0, 8'h80);
        dec(0, 32'h0010_0000, 1'b1, 8'h00);
        $display("t_boot done");
    endtask : t_boot
    task t_sel;
        dec(1, 32'h0bff_ffff, 1'b0, 8'h20);
        dec(1, 32'h0c00_0000, 1'b1, 8'h10);
        dec(1, 32'h0e00_0000, 1'b0, 8'h08);
        dec(1, 32'h1000_0000, 1'b0, 8'h00);
        dec(2, 32'h0334_0c00, 1'b0, 8'h04);
        dec(2, 32'h032c_0c00, 1'b1, 8'h04);
        dec(2, 32'h0324_0cff, 1'b0, 8'h04);
        dec(3, 32'h0302_baff, 1'b0, 8'h02);
        dec(4, 32'h0302_b000, 1'b1, 8'h01);
        dec(4, 32'h0302_b7ff, 1'b0, 8'h00);
        dec(5, 32'h0302_ba00, 1'b1, 8'h00);
        $display("t_sel done");
    endtask : t_sel
    task irq(input logic [21:0] v, input logic [8:0] e);
        src = v;
        repeat (4) @(posedge clk_sys);
        #1 chk({23'h0, cpu_irq}, {23'h0, e});
        chk({25'h0, simm_status}, {25'h0, v[6:0]});
    endtask : irq
    task t_irq;
        irq(22'h20_0000, 9'h001);
        irq(22'h00_0040, 9'h040);
        irq(22'h20, 9'h008);
        irq(22'h10, 9'h010);
        irq(22'h08, 9'h002);
        irq(22'h04, 9'h020);
        irq(22'h02, 9'h100);
        irq(22'h01, 9'h080);
        $display("t_irq done");
    endtask : t_irq
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        t_norm;
        t_boot;
        t_sel;
        t_irq;
        end_sim;
    end
    // Whole run needs under a hundred cycles
    initial
    begin
        #100000;
        errors++;
        end_sim;
    end
endmodule : board_address_decode_irq_routing_bench
